// ===== ptdg_top.sv
`timescale 1ns/1ps
`include "ptdg_regs.svh"

module ptdg_top
  import ptdg_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `PTDG_MS_CYCLES,
  parameter int unsigned SCAN_CYCLES = `PTDG_SCAN_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ch0_pulse_out,
  output logic ch0_dir_out,
  output logic ch1_pulse_out,
  output logic ch1_dir_out,
  output logic ch0_done_flag,
  output logic ch1_done_flag,
  output logic ch0_paused_flag,
  output logic ch1_paused_flag
);

  // ==================================================
  // apb decode
  wire access = psel & penable;
  wire [3:0] reg_idx = paddr[5:2];
  wire ch_sel = paddr[`PTDG_CH_STRIDE_BIT];
  wire unmapped = (paddr[11:7] != 5'h00) | (reg_idx > `PTDG_REG_STATUS);
  wire wr_ok = access & pwrite & ~unmapped;

  logic [31:0] rd_ch [2];
  logic pulse_w [2];
  logic dir_w [2];
  logic done_w [2];
  logic paused_w [2];

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access & unmapped;
  assign prdata = (access & ~pwrite & ~unmapped) ? rd_ch[ch_sel] : 32'h00000000;

  // ==================================================
  // channel pin mapping
  assign ch0_pulse_out = pulse_w[0];
  assign ch0_dir_out = dir_w[0];
  assign ch1_pulse_out = pulse_w[1];
  assign ch1_dir_out = dir_w[1];
  assign ch0_done_flag = done_w[0];
  assign ch1_done_flag = done_w[1];
  assign ch0_paused_flag = paused_w[0];
  assign ch1_paused_flag = paused_w[1];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    // software registers
    logic en, rel_mode, dir_invert, pause_req, sep_decel_en, ramp_stop_en;
    logic [31:0] freq_cmd, count_cmd, base_freq;
    logic [15:0] ramp_time, decel_time;
    // working state
    ptdg_state_t state;
    logic [31:0] remaining, err, halt_cnt, pos;
    logic [16:0] cur_f, tgt_f, start_f;
    logic [15:0] ramp_l, dec_l;
    logic dir_r, inv_l, sep_l, rstop_l, stopping, done, paused, dir_q;

    wire wr_ch = wr_ok & (ch_sel == 1'(c));
    wire wr_ctrl = wr_ch & (reg_idx == `PTDG_REG_CTRL);
    wire wr_stat = wr_ch & (reg_idx == `PTDG_REG_STATUS);

    // ==================================================
    // register writes
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        {ramp_stop_en, sep_decel_en, pause_req, dir_invert, rel_mode, en} <= 6'h00;
      end else if (wr_ctrl) begin
        {ramp_stop_en, sep_decel_en, pause_req, dir_invert, rel_mode, en} <= pwdata[5:0];
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        freq_cmd <= 32'h00000000;
        count_cmd <= 32'h00000000;
        ramp_time <= `PTDG_MS_RESET;
        decel_time <= `PTDG_MS_RESET;
        base_freq <= `PTDG_BASE_RESET;
      end else if (wr_ch) begin
        if (reg_idx == `PTDG_REG_FREQ) freq_cmd <= pwdata;
        if (reg_idx == `PTDG_REG_COUNT) count_cmd <= pwdata;
        if (reg_idx == `PTDG_REG_RAMP) ramp_time <= pwdata[15:0];
        if (reg_idx == `PTDG_REG_DECEL) decel_time <= pwdata[15:0];
        if (reg_idx == `PTDG_REG_BASE) base_freq <= pwdata;
      end
    end

    // ==================================================
    // velocity command decode
    wire vel_neg = freq_cmd[31];
    wire [16:0] vel_mag = ptdg_vel_mag(freq_cmd);
    wire [16:0] req_tgt = ptdg_clamp_hz(freq_cmd);
    wire [16:0] req_base = ptdg_clamp_hz(base_freq);

    // ==================================================
    // linear ramp: bresenham over the ramp time in clocks
    wire [15:0] dec_eff = sep_l ? dec_l : ramp_l;
    wire [43:0] dec_need = 44'(cur_f + start_f) * 44'(dec_eff);
    wire [43:0] dec_have = 44'(remaining) * `PTDG_DECEL_DIV;
    // remaining pulses no more than the area under the ramp-down
    wire decel = stopping | (dec_have <= dec_need);
    wire [15:0] ms_eff = decel ? dec_eff : ramp_l;
    wire [31:0] ramp_total = 32'(ms_eff) * 32'(MS_CYCLES);
    wire [16:0] span = tgt_f - start_f;
    wire [31:0] err_sum = err + 32'(span);
    wire bump = err_sum >= ramp_total;

    // ==================================================
    // pulse engine
    wire gen_run = ((state == ST_VEL_RUN) & (vel_mag != 17'h00000))
                 | ((state == ST_REL_RUN) & ~pause_req);
    wire [16:0] gen_freq = (state == ST_VEL_RUN) ? vel_mag : cur_f;
    wire step;

    ptdg_pulse_gen u_gen (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .run(gen_run),
      .freq(gen_freq),
      .pulse_out(pulse_w[c]),
      .step(step)
    );

    wire last_step = step & (remaining == 32'h00000001);
    wire ramp_end = stopping & (cur_f <= start_f);
    wire rel_abort = ~en & ~stopping & ~(rstop_l & ~pause_req);
    wire set_done = ((state == ST_REL_RUN) & (last_step | ramp_end))
                  | (((state == ST_VEL_RUN) | (state == ST_VEL_HALT)) & ~en);
    wire start = (state == ST_IDLE) & en;

    // ==================================================
    // command sequencer
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        state <= ST_IDLE;
        dir_r <= 1'b0;
        inv_l <= 1'b0;
        sep_l <= 1'b0;
        rstop_l <= 1'b0;
        stopping <= 1'b0;
        halt_cnt <= 32'h00000000;
        remaining <= 32'h00000000;
        tgt_f <= `PTDG_FREQ_MIN;
        start_f <= `PTDG_FREQ_MIN;
        ramp_l <= `PTDG_MS_RESET;
        dec_l <= `PTDG_MS_RESET;
      end else begin
        case (state)
          ST_IDLE: begin
            stopping <= 1'b0;
            if (en) begin
              // move settings are captured here and later writes wait, except freq_cmd, which velocity mode follows live
              inv_l <= dir_invert;
              sep_l <= sep_decel_en;
              rstop_l <= ramp_stop_en;
              ramp_l <= ptdg_clamp_ms(ramp_time);
              dec_l <= ptdg_clamp_ms(decel_time);
              tgt_f <= req_tgt;
              start_f <= (req_base < req_tgt) ? req_base : req_tgt;
              remaining <= count_cmd[31] ? 32'(-count_cmd) : count_cmd;
              dir_r <= rel_mode ? count_cmd[31] : vel_neg;
              if (!rel_mode) state <= ST_VEL_RUN;
              else if (count_cmd == 32'h00000000) state <= ST_REL_DONE;
              else state <= ST_REL_RUN;
            end
          end
          ST_VEL_RUN: begin
            if (!en) begin
              state <= ST_IDLE;
            end else if (vel_neg != dir_r) begin
              halt_cnt <= 32'(SCAN_CYCLES - 1);
              state <= ST_VEL_HALT;
            end
          end
          ST_VEL_HALT: begin
            if (!en) begin
              state <= ST_IDLE;
            end else if (halt_cnt == 32'h00000000) begin
              dir_r <= vel_neg;
              state <= ST_VEL_RUN;
            end else begin
              halt_cnt <= halt_cnt - 32'h00000001;
            end
          end
          ST_REL_RUN: begin
            if (step) remaining <= remaining - 32'h00000001;
            if (last_step) begin
              state <= ST_REL_DONE;
            end else if (ramp_end | rel_abort) begin
              state <= ST_IDLE;
            end else if (!en) begin
              stopping <= 1'b1;
            end
          end
          ST_REL_DONE: begin
            if (!en) state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end

    // ==================================================
    // ramp rate
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        cur_f <= `PTDG_FREQ_MIN;
        err <= 32'h00000000;
      end else if (start | (state != ST_REL_RUN) | pause_req) begin
        // a relative move, and a resume after pause, ramps up from the start rate
        cur_f <= start ? ((req_base < req_tgt) ? req_base : req_tgt) : start_f;
        err <= 32'h00000000;
      end else begin
        err <= bump ? err_sum - ramp_total : err_sum;
        if (bump & decel & (cur_f > start_f)) cur_f <= cur_f - 17'h00001;
        else if (bump & ~decel & (cur_f < tgt_f)) cur_f <= cur_f + 17'h00001;
      end
    end

    // ==================================================
    // position, flags and direction pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) pos <= 32'h00000000;
      else if (step) pos <= dir_r ? pos - 32'h00000001 : pos + 32'h00000001;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) done <= 1'b0;
      else if (set_done) done <= 1'b1;
      else if (start | (wr_stat & pwdata[`PTDG_STAT_DONE])) done <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        paused <= 1'b0;
        dir_q <= 1'b0;
      end else begin
        paused <= (state == ST_REL_RUN) & pause_req & ~last_step;
        // direction released only when the channel returns to idle
        dir_q <= (state != ST_IDLE) & (dir_r ^ inv_l);
      end
    end

    assign dir_w[c] = dir_q;
    assign done_w[c] = done;
    assign paused_w[c] = paused;

    // ==================================================
    // read mux
    wire [31:0] status_word = {28'h0000000, dir_q, (state != ST_IDLE), paused, done};
    always_comb begin
      case (reg_idx)
        `PTDG_REG_CTRL: rd_ch[c] = {26'h0000000, ramp_stop_en, sep_decel_en,
                                    pause_req, dir_invert, rel_mode, en};
        `PTDG_REG_FREQ: rd_ch[c] = freq_cmd;
        `PTDG_REG_COUNT: rd_ch[c] = count_cmd;
        `PTDG_REG_RAMP: rd_ch[c] = {16'h0000, ramp_time};
        `PTDG_REG_DECEL: rd_ch[c] = {16'h0000, decel_time};
        `PTDG_REG_BASE: rd_ch[c] = base_freq;
        `PTDG_REG_POS_LOW: rd_ch[c] = {16'h0000, pos[15:0]};
        `PTDG_REG_POS_HIGH: rd_ch[c] = {16'h0000, pos[31:16]};
        `PTDG_REG_STATUS: rd_ch[c] = status_word;
        default: rd_ch[c] = 32'h00000000;
      endcase
    end
  end

endmodule

// ===== ptdg_regs.svh
`ifndef PTDG_REGS_SVH
`define PTDG_REGS_SVH

// ==================================================
// timing
`define PTDG_CLK_HZ 20000000
`define PTDG_MS_TIME_US 1000
`define PTDG_MS_CYCLES (`PTDG_CLK_HZ / 1000000 * `PTDG_MS_TIME_US)
`define PTDG_SCAN_TIME_US 1000
`define PTDG_SCAN_CYCLES (`PTDG_CLK_HZ / 1000000 * `PTDG_SCAN_TIME_US)

// ==================================================
// limits and reset values
`define PTDG_FREQ_MIN 17'h00006
`define PTDG_FREQ_MAX 17'h186A0
`define PTDG_MS_MIN 16'h0014
`define PTDG_MS_MAX 16'h7FFF
`define PTDG_MS_RESET 16'h0064
`define PTDG_BASE_RESET 32'h000000C8
`define PTDG_DECEL_DIV 44'h00000007D0

// ==================================================
// register word index within a channel; channel n at byte n * 0x40
`define PTDG_CH_STRIDE_BIT 6
`define PTDG_REG_CTRL 4'h0
`define PTDG_REG_FREQ 4'h1
`define PTDG_REG_COUNT 4'h2
`define PTDG_REG_RAMP 4'h3
`define PTDG_REG_DECEL 4'h4
`define PTDG_REG_BASE 4'h5
`define PTDG_REG_POS_LOW 4'h6
`define PTDG_REG_POS_HIGH 4'h7
`define PTDG_REG_STATUS 4'h8

// ==================================================
// control and status fields
`define PTDG_CTRL_EN 0
`define PTDG_CTRL_REL 1
`define PTDG_CTRL_INV 2
`define PTDG_CTRL_PAUSE 3
`define PTDG_CTRL_SEP 4
`define PTDG_CTRL_RSTOP 5
`define PTDG_STAT_DONE 0
`define PTDG_STAT_PAUSED 1
`define PTDG_STAT_BUSY 2
`define PTDG_STAT_DIR 3

`endif

// ===== ptdg_pkg.sv
`include "ptdg_regs.svh"

package ptdg_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VEL_RUN = 3'b001,
    ST_VEL_HALT = 3'b010,
    ST_REL_RUN = 3'b011,
    ST_REL_DONE = 3'b100
  } ptdg_state_t;

  function automatic logic [16:0] ptdg_clamp_hz(input logic [31:0] v);
    if (v < 32'(`PTDG_FREQ_MIN)) return `PTDG_FREQ_MIN;
    else if (v > 32'(`PTDG_FREQ_MAX)) return `PTDG_FREQ_MAX;
    else return v[16:0];
  endfunction

  function automatic logic [15:0] ptdg_clamp_ms(input logic [15:0] v);
    if (v < `PTDG_MS_MIN) return `PTDG_MS_MIN;
    else if (v > `PTDG_MS_MAX) return `PTDG_MS_MAX;
    else return v;
  endfunction

  function automatic logic [16:0] ptdg_vel_mag(input logic [31:0] v);
    logic [31:0] m;
    m = v[31] ? 32'(-v) : v;
    if (m > 32'(`PTDG_FREQ_MAX)) return `PTDG_FREQ_MAX;
    else return m[16:0];
  endfunction

endpackage

// ===== ptdg_pulse_gen.sv
`timescale 1ns/1ps
`include "ptdg_regs.svh"

module ptdg_pulse_gen
  import ptdg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [16:0] freq,
  output logic pulse_out,
  output logic step
);

  localparam logic [25:0] CLK_HZ = 26'(`PTDG_CLK_HZ);

  logic [25:0] acc;
  wire [25:0] acc_sum = acc + {8'h00, freq, 1'b0};
  wire wrap = acc_sum >= CLK_HZ;

  // ==================================================
  // half-period accumulator: toggles at twice the rate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 26'h0000000;
      pulse_out <= 1'b0;
      step <= 1'b0;
    end else if (!run) begin
      // dropping run kills the pulse mid-period, no tail
      acc <= 26'h0000000;
      pulse_out <= 1'b0;
      // a cut high phase still ends in a falling edge that the drive counts
      step <= pulse_out;
    end else begin
      acc <= wrap ? acc_sum - CLK_HZ : acc_sum;
      pulse_out <= wrap ? ~pulse_out : pulse_out;
      // a pulse counts at its falling edge
      step <= wrap & pulse_out;
    end
  end

endmodule

// ===== ptdg_asserts.sv
`timescale 1ns/1ps
// ====
// port checker for the pulse and direction generator
module ptdg_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ch0_pulse_out,
  input wire logic ch0_dir_out,
  input wire logic ch1_pulse_out,
  input wire logic ch1_dir_out,
  input wire logic ch0_done_flag,
  input wire logic ch1_done_flag,
  input wire logic ch0_paused_flag,
  input wire logic ch1_paused_flag
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  wire stop0 = psel && penable && pwrite && paddr == 12'h000 && !pwdata[0];
  wire clr0 = psel && penable && pwrite && paddr == 12'h020 && pwdata[0];
  // an enable drop may cut a high phase short, so only the low phase gets a floor
  chk_low_phase0: assert property ($fell(ch0_pulse_out) |=> !ch0_pulse_out [*6])
    else $error("ch0 low phase too short");
  chk_low_phase1: assert property ($fell(ch1_pulse_out) |=> !ch1_pulse_out [*6])
    else $error("ch1 low phase too short");
  chk_stop_fast: assert property (stop0 |-> ##3 !ch0_pulse_out [*8])
    else $error("ch0 pulses continue after enable drop");
  chk_done_clear: assert property ($fell(ch0_done_flag) |-> $past(clr0))
    else $error("ch0 done fell without a clear write");
  chk_dir_steady0: assert property ($rose(ch0_pulse_out) |=> $stable(ch0_dir_out) [*8])
    else $error("ch0 direction moved during a step");
  chk_dir_steady1: assert property ($rose(ch1_pulse_out) |=> $stable(ch1_dir_out) [*8])
    else $error("ch1 direction moved during a step");
  chk_pause_still: assert property (ch0_paused_flag && $past(ch0_paused_flag, 3) |-> !ch0_pulse_out)
    else $error("ch0 pulses while paused");
  chk_done_quiet0: assert property (ch0_done_flag |-> !$rose(ch0_pulse_out))
    else $error("ch0 pulse after done");
  chk_done_quiet1: assert property (ch1_done_flag |-> !$rose(ch1_pulse_out))
    else $error("ch1 pulse after done");
endmodule

// ===== ptdg_drive_model.sv
`timescale 1ns/1ps
// ====
// drive stand-in: counts steps, low direction means forward
module ptdg_drive_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic step_in,
  input wire logic dir_in,
  output logic signed [31:0] steps,
  output logic [31:0] high_len
);
  logic step_q;
  logic [31:0] run_len;
  wire fell = step_q && !step_in;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 1'b0;
      steps <= 32'sh0;
      run_len <= 32'h0;
      high_len <= 32'h0;
    end else begin
      step_q <= step_in;
      run_len <= step_in ? run_len + 32'h1 : 32'h0;
      // the drive latches a step on its falling edge
      if (fell) begin
        steps <= dir_in ? steps - 32'sh1 : steps + 32'sh1;
        high_len <= run_len;
      end
    end
  end
endmodule

// ===== two_channel_pulse_dir_generator_test.sv
`timescale 1ns/1ps
module two_channel_pulse_dir_generator_test;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, hl0, hl1;
  logic ch0_pulse_out, ch0_dir_out, ch1_pulse_out, ch1_dir_out;
  logic ch0_done_flag, ch1_done_flag, ch0_paused_flag, ch1_paused_flag;
  logic signed [31:0] steps0, steps1, p0;
  int num_errors, check_count;
  int waited;

  ptdg_top #(.MS_CYCLES(20), .SCAN_CYCLES(8)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch0_pulse_out(ch0_pulse_out),
    .ch0_dir_out(ch0_dir_out), .ch1_pulse_out(ch1_pulse_out), .ch1_dir_out(ch1_dir_out),
    .ch0_done_flag(ch0_done_flag), .ch1_done_flag(ch1_done_flag),
    .ch0_paused_flag(ch0_paused_flag), .ch1_paused_flag(ch1_paused_flag));
  ptdg_drive_model i_drv0 (.clk_sys(clk_sys), .rst_n(rst_n), .step_in(ch0_pulse_out),
    .dir_in(ch0_dir_out), .steps(steps0), .high_len(hl0));
  ptdg_drive_model i_drv1 (.clk_sys(clk_sys), .rst_n(rst_n), .step_in(ch1_pulse_out),
    .dir_in(ch1_dir_out), .steps(steps1), .high_len(hl1));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ====
  // access and compare helpers
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50) begin
      cmp(32'h0, 32'h1, "pready timeout");
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    cmp(q, exp, m);
  endtask

  task automatic pos(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] lo;
    apb(1'b0, a + 12'h018, 32'h0);
    lo = q;
    apb(1'b0, a + 12'h01C, 32'h0);
    cmp({q[15:0], lo[15:0]}, exp, "position");
  endtask

  task automatic wait_done(input logic ch);
    int n;
    n = 0;
    while ((ch ? ch1_done_flag : ch0_done_flag) !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      if (n > 20000) begin
        cmp(32'h0, 32'h1, "done wait timed out");
        conclude();
      end
    end
    waited = n;
  endtask

  // ====
  // tests
  initial begin
    {psel, penable, pwrite, rst_n} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    num_errors = 0;
    check_count = 0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdc(12'h00C, 32'h00000064, "ramp reset");
    rdc(12'h050, 32'h00000064, "decel reset");
    rdc(12'h054, 32'h000000C8, "base reset");
    apb(1'b1, 12'h018, 32'h00001234);
    rdc(12'h018, 32'h00000000, "position is read only");
    rdc(12'h300, 32'h00000000, "unmapped read");
    cmp({31'h0, e}, 32'h1, "unmapped error");
    $display("test reset_map done");
    apb(1'b1, 12'h004, 32'h00030D40);
    apb(1'b1, 12'h000, 32'h00000001);
    repeat (600) @(posedge clk_sys);
    cmp(hl0, 32'h00000064, "velocity clamped half period");
    cmp({31'h0, ch0_dir_out}, 32'h0, "forward direction");
    apb(1'b1, 12'h004, 32'hFFFE7960);
    repeat (700) @(posedge clk_sys);
    cmp({31'h0, ch0_dir_out}, 32'h1, "reversed direction");
    cmp(hl0, 32'h00000064, "new rate without ramp");
    apb(1'b1, 12'h000, 32'h00000000);
    wait_done(1'b0);
    pos(12'h000, steps0);
    apb(1'b1, 12'h020, 32'h00000001);
    p0 = steps0;
    $display("test velocity done");
    apb(1'b1, 12'h054, 32'h000186A0);
    apb(1'b1, 12'h044, 32'h000186A0);
    apb(1'b1, 12'h048, 32'hFFFFFFFB);
    apb(1'b1, 12'h040, 32'h00000003);
    wait_done(1'b1);
    repeat (20) @(posedge clk_sys);
    cmp(steps1, 32'hFFFFFFFB, "relative count");
    cmp(steps0, p0, "other channel idle");
    cmp({31'h0, ch1_dir_out}, 32'h1, "direction held after move");
    pos(12'h040, 32'hFFFFFFFB);
    apb(1'b1, 12'h040, 32'h00000000);
    repeat (3) @(posedge clk_sys);
    cmp({31'h0, ch1_dir_out}, 32'h0, "direction released");
    $display("test relative done");
    apb(1'b1, 12'h014, 32'h000186A0);
    apb(1'b1, 12'h008, 32'h00000006);
    apb(1'b1, 12'h000, 32'h00000007);
    repeat (450) @(posedge clk_sys);
    apb(1'b1, 12'h008, 32'h00000064);
    apb(1'b1, 12'h000, 32'h0000000F);
    repeat (3) @(posedge clk_sys);
    cmp({31'h0, ch0_paused_flag}, 32'h1, "paused flag");
    cmp({31'h0, ch1_paused_flag}, 32'h0, "other channel not paused");
    q = steps0;
    repeat (400) @(posedge clk_sys);
    cmp(steps0, q, "no steps while paused");
    apb(1'b1, 12'h000, 32'h00000007);
    repeat (3) @(posedge clk_sys);
    cmp({31'h0, ch0_paused_flag}, 32'h0, "pause released");
    wait_done(1'b0);
    repeat (20) @(posedge clk_sys);
    cmp({31'h0, ch0_dir_out}, 32'h1, "inverted direction");
    cmp(steps0 - p0, 32'hFFFFFFFA, "count after pause");
    pos(12'h000, p0 + 32'sh6);
    apb(1'b1, 12'h000, 32'h00000000);
    $display("test pause done");
    apb(1'b1, 12'h054, 32'h00002710);
    apb(1'b1, 12'h044, 32'h00002EE0);
    apb(1'b1, 12'h048, 32'h00010000);
    apb(1'b1, 12'h050, 32'h000000C8);
    apb(1'b1, 12'h040, 32'h00000033);
    repeat (1000) @(posedge clk_sys);
    apb(1'b1, 12'h040, 32'h00000030);
    q = steps1;
    wait_done(1'b1);
    // about 1000 Hz down to the base rate at half a hertz per clock
    cmp({31'h0, (waited > 1900 && waited < 2100)}, 32'h1, "separate ramp-down time");
    cmp({31'h0, (steps1 != q)}, 32'h1, "pulses during ramp-down");
    repeat (20) @(posedge clk_sys);
    pos(12'h040, steps1);
    apb(1'b1, 12'h040, 32'h00000000);
    $display("test ramp_stop done");
    conclude();
  end
endmodule

bind ptdg_top ptdg_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ch0_pulse_out(ch0_pulse_out),
  .ch0_dir_out(ch0_dir_out), .ch1_pulse_out(ch1_pulse_out), .ch1_dir_out(ch1_dir_out),
  .ch0_done_flag(ch0_done_flag), .ch1_done_flag(ch1_done_flag),
  .ch0_paused_flag(ch0_paused_flag), .ch1_paused_flag(ch1_paused_flag));
